//--- rtl/udma_din_consts.vh
// Timing and protocol constants for the Ultra DMA data-in pause and termination block
`ifndef UDMA_DIN_CONSTS_VH
`define UDMA_DIN_CONSTS_VH

// System clock period
`define CLK_PERIOD_NS   40
// Least data setup time before a strobe edge
`define T_DVS_NS        70
// Least spacing between two strobe edges
`define T_CYC_NS        120
// Least time from the last strobe edge to request negation
`define T_SS_NS         50

// Least times round up to whole cycles
`define DVS_CYC ((`T_DVS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_CYC ((`T_CYC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SS_CYC  ((`T_SS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_CYC ((`CYC_CYC > `SS_CYC) ? `CYC_CYC : `SS_CYC)

// Burst state codes
`define ST_IDLE 3'h0
`define ST_REQ  3'h1
`define ST_WAIT 3'h2
`define ST_XFER 3'h3
`define ST_SETUP 3'h4
`define ST_TERM 3'h5

// Checksum defaults
`define CRC_POLY_DEF 16'h1021
`define CRC_SEED_DEF 16'h4aba

// Bus widths
`define DATA_W 16
`define SYNC_W 19
`endif

//--- rtl/udma_word_fifo.v
// Word FIFO with a registered output stage between user data and the strobe engine
module udma_word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_in,
  input  wire             resetn_in,
  input  wire [WIDTH-1:0] in_data_in,
  input  wire             in_valid_in,
  output reg              in_ready_out,
  output reg  [WIDTH-1:0] out_data_out,
  output reg              out_valid_out,
  input  wire             out_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  reg [AW:0]      count_d;
  wire            push;
  wire            pop;

  assign push = in_valid_in & in_ready_out;
  assign pop  = (count_q != {(AW+1){1'b0}}) & (~out_valid_out | out_ready_in);

  always @* begin
    count_d = count_q;
    if (push & ~pop) begin
      count_d = count_q + 1'b1;
    end else if (pop & ~push) begin
      count_d = count_q - 1'b1;
    end
  end

  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_in;
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_q      <= {AW{1'b0}};
      rd_ptr_q      <= {AW{1'b0}};
      count_q       <= {(AW+1){1'b0}};
      in_ready_out  <= 1'b0;
      out_valid_out <= 1'b0;
      out_data_out  <= {WIDTH{1'b0}};
    end else begin
      count_q      <= count_d;
      in_ready_out <= (count_d < DEPTH);
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        out_data_out  <= mem[rd_ptr_q];
        out_valid_out <= 1'b1;
        rd_ptr_q      <= (rd_ptr_q == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
      end else if (out_ready_in) begin
        out_valid_out <= 1'b0;
      end
    end
  end
endmodule // udma_word_fifo

//--- rtl/udma_data_in_pause_terminate.v
// Device end of an Ultra DMA data-in burst: strobing, pausing, termination and checksum exchange
//
// Overview of operation
// - Device never pauses a burst before its first word has gone out.
// - Device pauses by withholding strobe edges and resumes with the next edge.
// - Device stops strobing promptly once host ready is negated.
// - Device ends burst by dropping request at least tSS after last edge.
// - Device releases the data bus in the same cycle as it drops request.
// - Low strobe is raised after stop without data and held to the end.
// - Device captures the host checksum when acknowledge is negated.
// - Device compares checksums and reports only the first miscompare per command.
// - Device releases the strobe pin promptly after acknowledge is negated.
// - Device drops request soon after stop and keeps it low to the end.
`include "udma_din_consts.vh"
module udma_data_in_pause_terminate #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3,
  parameter CRC_POLY   = `CRC_POLY_DEF,
  parameter CRC_SEED   = `CRC_SEED_DEF
) (
  input  wire                CLK_SYS_IN,
  input  wire                RESETN_IN,
  input  wire [`DATA_W-1:0]  WORD_IN,
  input  wire                WORD_VALID_IN,
  output wire                WORD_READY_OUT,
  input  wire                BURST_REQ_IN,
  input  wire                PAUSE_IN,
  input  wire                TERMINATE_IN,
  input  wire                CMD_DONE_IN,
  output reg                 CRC_ERR_OUT,
  output reg                 CRC_REPORT_OUT,
  output reg                 BURST_ACTIVE_OUT,
  output reg                 DMARQ_OUT,
  input  wire                DMACK_N_IN,
  input  wire                STOP_IN,
  input  wire                HDMARDY_N_IN,
  output reg                 DSTROBE_OUT,
  output reg                 DSTROBE_OE_N_OUT,
  input  wire [`DATA_W-1:0]  DD_IN,
  output reg  [`DATA_W-1:0]  DD_OUT,
  output reg                 DD_OE_N_OUT
);
  localparam integer DVS_INT = `DVS_CYC;
  localparam integer GAP_INT = `GAP_CYC;
  localparam [3:0]   DVS_CYC = DVS_INT[3:0];
  localparam [3:0]   GAP_CYC = GAP_INT[3:0];

  function [15:0] crc_next;
    input [15:0] crc;
    input [15:0] data;
    integer i;
    reg [15:0] c;
    begin
      c = crc;
      for (i = 15; i >= 0; i = i - 1) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ data[i]) ? CRC_POLY : 16'h0000);
      end
      crc_next = c;
    end
  endfunction

  reg  [`SYNC_W-1:0] sync1_q;
  reg  [`SYNC_W-1:0] sync2_q;
  reg                dmack_n_prev_q;
  reg  [2:0]         state_q;
  reg  [3:0]         cnt_q;
  reg                first_done_q;
  reg  [15:0]        crc_q;
  reg                err_q;
  wire               dmack_n_s;
  wire               stop_s;
  wire               hdmardy_n_s;
  wire [15:0]        dd_s;
  wire               dmack_rise;
  wire [15:0]        fifo_data;
  wire               fifo_valid;
  wire               fifo_pop;
  wire               may_strobe;
  wire               dev_term;
  wire               miscmp;

  udma_word_fifo #(
    .WIDTH (`DATA_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_in        (CLK_SYS_IN),
    .resetn_in     (RESETN_IN),
    .in_data_in    (WORD_IN),
    .in_valid_in   (WORD_VALID_IN),
    .in_ready_out  (WORD_READY_OUT),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop)
  );

  // Pin synchronisers
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      sync1_q        <= {3'h7, 16'h0000};
      sync2_q        <= {3'h7, 16'h0000};
      dmack_n_prev_q <= 1'b1;
    end else begin
      sync1_q        <= {DMACK_N_IN, STOP_IN, HDMARDY_N_IN, DD_IN};
      sync2_q        <= sync1_q;
      dmack_n_prev_q <= sync2_q[18];
    end
  end

  assign dmack_n_s   = sync2_q[18];
  assign stop_s      = sync2_q[17];
  assign hdmardy_n_s = sync2_q[16];
  assign dd_s        = sync2_q[15:0];
  assign dmack_rise  = dmack_n_s & ~dmack_n_prev_q;

  // Next word may be launched only with host ready and, once the first word is out, no pause or termination pending
  assign may_strobe = (state_q == `ST_XFER) & (cnt_q == 4'h0) & fifo_valid & ~hdmardy_n_s & ~stop_s
                    & ~(PAUSE_IN & first_done_q)
                    & ~(TERMINATE_IN & first_done_q);
  assign fifo_pop   = may_strobe;
  assign dev_term   = (state_q == `ST_XFER) & (cnt_q == 4'h0) & TERMINATE_IN & first_done_q;
  assign miscmp     = (state_q == `ST_TERM) & dmack_rise & (dd_s != crc_q);

  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_q          <= `ST_IDLE;
      cnt_q            <= 4'h0;
      first_done_q     <= 1'b0;
      crc_q            <= 16'h0000;
      DMARQ_OUT        <= 1'b0;
      DSTROBE_OUT      <= 1'b1;
      DSTROBE_OE_N_OUT <= 1'b1;
      DD_OUT           <= 16'h0000;
      DD_OE_N_OUT      <= 1'b1;
      BURST_ACTIVE_OUT <= 1'b0;
    end else begin
      case (state_q)
        `ST_IDLE: begin
          if (BURST_REQ_IN) begin
            DMARQ_OUT        <= 1'b1;
            crc_q            <= CRC_SEED;
            first_done_q     <= 1'b0;
            BURST_ACTIVE_OUT <= 1'b1;
            state_q          <= `ST_REQ;
          end
        end
        `ST_REQ: begin
          if (!dmack_n_s) begin
            DSTROBE_OUT      <= 1'b1;
            DSTROBE_OE_N_OUT <= 1'b0;
            state_q          <= `ST_WAIT;
          end
        end
        `ST_WAIT: begin
          if (dmack_n_s) begin
            DSTROBE_OE_N_OUT <= 1'b1;
            DMARQ_OUT        <= 1'b0;
            BURST_ACTIVE_OUT <= 1'b0;
            state_q          <= `ST_IDLE;
          end else if (!stop_s && !hdmardy_n_s) begin
            cnt_q   <= 4'h0;
            state_q <= `ST_XFER;
          end
        end
        `ST_XFER: begin
          if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
          end
          if (stop_s || dev_term) begin
            DMARQ_OUT   <= 1'b0;
            DD_OE_N_OUT <= 1'b1;
            state_q     <= `ST_TERM;
          end else if (may_strobe) begin
            DD_OUT      <= fifo_data;
            DD_OE_N_OUT <= 1'b0;
            crc_q       <= crc_next(crc_q, fifo_data);
            cnt_q       <= DVS_CYC - 4'h1;
            state_q     <= `ST_SETUP;
          end
        end
        `ST_SETUP: begin
          if (cnt_q == 4'h0) begin
            DSTROBE_OUT  <= ~DSTROBE_OUT;
            first_done_q <= 1'b1;
            cnt_q        <= GAP_CYC;
            state_q      <= `ST_XFER;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        `ST_TERM: begin
          DMARQ_OUT   <= 1'b0;
          DD_OE_N_OUT <= 1'b1;
          if (stop_s && !DSTROBE_OUT) begin
            DSTROBE_OUT <= 1'b1;
          end
          if (dmack_rise) begin
            DSTROBE_OE_N_OUT <= 1'b1;
            BURST_ACTIVE_OUT <= 1'b0;
            state_q          <= `ST_IDLE;
          end
        end
        default: begin
          state_q <= `ST_IDLE;
        end
      endcase
    end
  end

  // First checksum error of a command is held until the command ends
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      err_q          <= 1'b0;
      CRC_ERR_OUT    <= 1'b0;
      CRC_REPORT_OUT <= 1'b0;
    end else begin
      CRC_REPORT_OUT <= CMD_DONE_IN;
      if (CMD_DONE_IN) begin
        CRC_ERR_OUT <= err_q | miscmp;
        err_q       <= 1'b0;
      end else if (miscmp) begin
        err_q <= 1'b1;
      end
    end
  end
endmodule // udma_data_in_pause_terminate

//--- testbench/udma_din_checker_assertions.sv
// Concurrent checks on the data-in pause and termination block ports
module udma_din_checker (
  input wire CLK_SYS_IN,
  input wire RESETN_IN,
  input wire DMARQ_OUT,
  input wire DMACK_N_IN,
  input wire STOP_IN,
  input wire HDMARDY_N_IN,
  input wire DSTROBE_OUT,
  input wire DSTROBE_OE_N_OUT,
  input wire DD_OE_N_OUT,
  input wire CMD_DONE_IN,
  input wire CRC_REPORT_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen_q;
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);
  // Set once a data edge has gone out in this burst
  always @(posedge CLK_SYS_IN)
    if (!RESETN_IN) seen_q <= 1'b0;
    else if ($rose(DMARQ_OUT)) seen_q <= 1'b0;
    else if ($fell(DSTROBE_OUT) && !DSTROBE_OE_N_OUT) seen_q <= 1'b1;
  chk_rq_after_word: assert property ($fell(DMARQ_OUT) |-> seen_q)
    else $error("request dropped before first word");
  chk_pause_no_edge: assert property ((HDMARDY_N_IN && !STOP_IN && !DMACK_N_IN)[*8] |-> $stable(DSTROBE_OUT))
    else $error("strobe edge while host not ready");
  chk_stop_drops_rq: assert property ($rose(STOP_IN) && DMARQ_OUT |-> ##[1:4] !DMARQ_OUT)
    else $error("request not dropped after stop");
  chk_rq_held_low: assert property ($fell(DMARQ_OUT) |=> !DMARQ_OUT[*8])
    else $error("request raised during termination");
  chk_rq_after_edge: assert property ($changed(DSTROBE_OUT) && DMARQ_OUT && !STOP_IN |=> DMARQ_OUT[*2])
    else $error("request dropped too soon after edge");
  chk_bus_release: assert property ($fell(DMARQ_OUT) |-> DD_OE_N_OUT)
    else $error("data bus still driven");
  chk_term_strobe_high: assert property ($rose(STOP_IN) && !DMACK_N_IN |-> ##[1:6] DSTROBE_OUT)
    else $error("strobe not raised after stop");
  chk_strobe_held: assert property (STOP_IN && !DMARQ_OUT && !DMACK_N_IN && DSTROBE_OUT |=> DSTROBE_OUT)
    else $error("strobe dropped during termination");
  chk_strobe_release: assert property ($rose(DMACK_N_IN) |-> ##[1:5] DSTROBE_OE_N_OUT)
    else $error("strobe pin not released");
  chk_report_pulse: assert property (CMD_DONE_IN |=> CRC_REPORT_OUT ##1 !CRC_REPORT_OUT)
    else $error("checksum report pulse wrong");
endmodule // udma_din_checker

bind udma_data_in_pause_terminate udma_din_checker chk_u (.*);

//--- testbench/udma_host_model.sv
// Behavioural host adapter for data-in bursts
module udma_host_model (
  input  wire        clk_in,
  input  wire        dmarq_in,
  input  wire        dstrobe_in,
  input  wire [15:0] dd_in,
  input  wire        pause_in,
  input  wire        term_in,
  input  wire        bad_crc_in,
  output reg         dmack_n_out,
  output reg         stop_out,
  output reg         hdmardy_n_out,
  output reg         oe_out,
  output reg  [15:0] dd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] crc;
  logic [15:0] rx_q[$];
  int          nb = 0;
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [15:0] d);
    for (int k = 15; k >= 0; k--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  always @(dstrobe_in) if (!stop_out && !dmack_n_out) begin
    rx_q.push_back(dd_in);
    crc = crc_step(crc, dd_in);
  end
  initial begin
    {dmack_n_out, stop_out, hdmardy_n_out, oe_out} = 4'he;
    dd_out = 16'h0000;
    forever begin
      @(posedge clk_in iff dmarq_in);
      crc = 16'h4aba;
      @(posedge clk_in) dmack_n_out = 1'b0;
      @(posedge clk_in) {stop_out, hdmardy_n_out} = 2'h0;
      while (dmarq_in && !term_in) @(posedge clk_in) hdmardy_n_out = pause_in | term_in | !dmarq_in;
      if (dmarq_in) @(posedge clk_in);
      stop_out = 1'b1;
      @(posedge clk_in iff !dmarq_in) {oe_out, dd_out} = {1'b1, bad_crc_in ? ~crc : crc};
      @(posedge clk_in iff (dstrobe_in && !dmarq_in));
      @(posedge clk_in) dmack_n_out = 1'b1;
      repeat (2) @(posedge clk_in);
      oe_out = 1'b0;
      nb++;
    end
  end
endmodule // udma_host_model

//--- testbench/udma_data_in_pause_terminate_tb_top.sv
// Testbench for the data-in pause and termination block
module udma_data_in_pause_terminate_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, hclk, rst_n, wv, brq, pau, trm, done, h_pau, h_trm, h_bad;
  logic [15:0] w, flt;
  logic [15:0] sq[$];
  int          fails = 0, n_compared = 0, i, j;
  wire         wr, err, rep, act, rq, ds, ds_oe_n, dd_oe_n, ack_n, stop, rdy_n, h_oe;
  wire  [15:0] dd_out, h_dd;
  wire  [15:0] dd_bus = h_oe ? h_dd : (dd_oe_n ? flt : dd_out);
  wire         ds_pin = ds_oe_n ? flt[0] : ds;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    hclk = 1'b0;
    #7;
    forever #160 hclk = ~hclk;
  end
  always @(posedge clk) flt <= ~flt;
  udma_data_in_pause_terminate DUT (
    .CLK_SYS_IN(clk), .RESETN_IN(rst_n), .WORD_IN(w), .WORD_VALID_IN(wv), .WORD_READY_OUT(wr),
    .BURST_REQ_IN(brq), .PAUSE_IN(pau), .TERMINATE_IN(trm), .CMD_DONE_IN(done), .CRC_ERR_OUT(err),
    .CRC_REPORT_OUT(rep), .BURST_ACTIVE_OUT(act), .DMARQ_OUT(rq), .DMACK_N_IN(ack_n), .STOP_IN(stop),
    .HDMARDY_N_IN(rdy_n), .DSTROBE_OUT(ds), .DSTROBE_OE_N_OUT(ds_oe_n), .DD_IN(dd_bus), .DD_OUT(dd_out),
    .DD_OE_N_OUT(dd_oe_n));
  udma_host_model host (.clk_in(hclk), .dmarq_in(rq), .dstrobe_in(ds_pin), .dd_in(dd_bus), .pause_in(h_pau),
    .term_in(h_trm), .bad_crc_in(h_bad), .dmack_n_out(ack_n), .stop_out(stop), .hdmardy_n_out(rdy_n),
    .oe_out(h_oe), .dd_out(h_dd));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task waitq(input int n, input bit by_burst);
    for (int k = 0; k < 5000 && (by_burst ? host.nb : host.rx_q.size()) < n; k++) @(negedge clk);
    chk((by_burst ? host.nb : host.rx_q.size()) >= n, 1'b1);
  endtask
  task push(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      if (!wr) break;
      wv = 1'b1;
      w = 16'ha000 + 16'(sq.size());
      sq.push_back(w);
    end
    @(negedge clk) wv = 1'b0;
  endtask
  task pulse_req;
    @(negedge clk) brq = 1'b1;
    @(negedge clk) brq = 1'b0;
  endtask
  task report(input logic e);
    @(negedge clk) done = 1'b1;
    @(negedge clk) done = 1'b0;
    chk(rep, 1'b1);
    chk(err, e);
    @(negedge clk);
    chk(rep, 1'b0);
  endtask
  task t_fill_pause_hterm;
    push(20);
    chk(sq.size() >= 8 && sq.size() <= 10, 1'b1);
    repeat (4) @(negedge clk);
    chk(wr, 1'b0);
    pulse_req;
    waitq(2, 0);
    chk(act, 1'b1);
    h_pau = 1'b1;
    j = host.rx_q.size();
    repeat (30) @(negedge clk);
    i = host.rx_q.size();
    chk(i - j <= 2, 1'b1);
    repeat (40) @(negedge clk);
    chk(16'(host.rx_q.size()), 16'(i));
    h_pau = 1'b0;
    waitq(i + 1, 0);
    chk(host.rx_q.size() > i, 1'b1);
    h_trm = 1'b1;
    waitq(1, 1);
    h_trm = 1'b0;
  endtask
  task t_dterm_err;
    push(4);
    {pau, trm, h_bad} = 3'h7;
    i = host.rx_q.size();
    pulse_req;
    waitq(2, 1);
    chk(16'(host.rx_q.size()), 16'(i + 1));
    {pau, trm, h_bad} = 3'h0;
    push(4);
    pulse_req;
    waitq(i + 2, 0);
    pau = 1'b1;
    j = host.rx_q.size();
    repeat (20) @(negedge clk);
    i = host.rx_q.size();
    chk(i - j <= 1, 1'b1);
    repeat (20) @(negedge clk);
    chk(16'(host.rx_q.size()), 16'(i));
    pau = 1'b0;
    waitq(sq.size(), 0);
    h_trm = 1'b1;
    waitq(3, 1);
    h_trm = 1'b0;
    chk(16'(host.rx_q.size()), 16'(sq.size()));
    for (int k = 0; k < host.rx_q.size(); k++) chk(host.rx_q[k], sq[k]);
    chk(act, 1'b0);
    report(1'b1);
    report(1'b0);
  endtask
  initial begin
    #2000000;
    fails++;
    conclude;
  end
  initial begin
    {rst_n, wv, brq, pau, trm, done, h_pau, h_trm, h_bad} = 9'h000;
    w = 16'h0000;
    flt = 16'ha5a5;
    repeat (2) @(posedge clk);
    chk({rq, ds_oe_n, dd_oe_n, wr}, 16'h0006);
    @(negedge clk) rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_fill_pause_hterm;
    t_dterm_err;
    conclude;
  end
endmodule // udma_data_in_pause_terminate_tb_top
